// *** common/dac_link_pkg.sv ***
// shared constants and types for the two-wire dac write link
package dac_link_pkg;
  // core clock of the bus-master end and the fastest legal serial clock
  localparam int CORE_CLK_KHZ = 10000;
  localparam int SCL_MAX_KHZ = 400;
  // quarter of an scl period in core cycles, rounded up so scl never exceeds max
  localparam int QTR_CYC = (CORE_CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
  localparam int QCW = 4;
  // spike suppression on both bus lines, in link clock cycles
  localparam int SPIKE_NS = 50;
  localparam int LINK_PERIOD_NS = 125;
  localparam int FILT_RAW = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam int FCW = 4;
  // byte framing
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  // fixed upper part of the seven-bit slave address
  localparam logic [6:0] ADDR_FIXED = 7'h28;
  // command byte fields
  localparam int CMD_CH_LSB = 0;
  localparam int CMD_CH_W = 3;
  localparam int CMD_PD_BIT = 3;
  localparam int CMD_RST_BIT = 4;
  // bus-master register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SLV_ADDR = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_PAIR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [1:0] LAST_IDX_LONE = 2'h1;
  localparam logic [1:0] LAST_IDX_PAIR = 2'h2;

  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_CMD, DS_DATA, DS_SKIP} dev_state_e;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BITS, HS_STOP} host_state_e;
endpackage

// *** common/two_wire_if.sv ***
// two-wire bus between the dac write slave and its bus master
`timescale 1ns/100ps
interface two_wire_if;
  logic link_clk;
  logic scl_do_h;
  logic scl_oe_h;
  logic sda_do_h;
  logic sda_oe_h;
  logic sda_do_d;
  logic sda_oe_d;
  logic scl;
  logic sda;

  // pulled-up lines: low only where an enabled driver pulls low
  assign scl = ~(scl_oe_h & ~scl_do_h);
  assign sda = ~((sda_oe_h & ~sda_do_h) | (sda_oe_d & ~sda_do_d));

  modport host (
    output scl_do_h,
    output scl_oe_h,
    output sda_do_h,
    output sda_oe_h,
    input scl,
    input sda
  );
  modport dev (
    input link_clk,
    input scl,
    input sda,
    output sda_do_d,
    output sda_oe_d
  );
endinterface

// *** rtl/dac_write_slave.sv ***
// receive-only two-wire slave of a multi-channel 8-bit dac with double-buffered latches
`timescale 1ns/100ps

// Behaviour
// - master leaves both lines high when idle
// - slave drives data line only for acknowledge
// - works from standstill up to 400 kHz
// - frame: start, address, command/output pairs, stop
// - master changes data only while clock low
// - sample data on clock high; edges frame
// - msb first, eight bits plus ack slot
// - slave pulls data low in ninth clock
// - master releases data line in ninth clock
// - both lines filtered against short spikes
// - address select pins form low address bits
// - seven-bit address match, write bit only
// - output byte to selected channel, copied at stop
// - last command power-down bit applied at stop
// - clear bit zeroes inputs, skips next output
module dac_write_slave #(
  parameter int NUM_CH = 4,
  parameter int ADDR_PINS = 3
) (
  two_wire_if.dev link,
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic addr_select_pin_0_i,
  input wire logic addr_select_pin_1_i,
  input wire logic addr_select_pin_2_i,
  output logic [NUM_CH*8-1:0] dac_code_o,
  output logic power_down_o,
  output logic update_o
);
  localparam int CHW = $clog2(NUM_CH);
  localparam logic [6:0] PIN_MASK = 7'((1 << ADDR_PINS) - 1);
  localparam int CMD_CH_W_L = dac_link_pkg::CMD_CH_W;
  localparam int FCW = dac_link_pkg::FCW;

  logic lrst_meta_r;
  logic lrst_n_r;
  logic [1:0] line_raw;
  logic [1:0] line_meta_r;
  logic [1:0] line_sync_r;
  logic [1:0] filt_r;
  logic [FCW-1:0] filt_cnt_r [2];
  logic scl_q_r;
  logic sda_q_r;
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic [6:0] my_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic [7:0] rx_byte;
  logic addr_hit;
  dac_link_pkg::dev_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic ack_on_r;
  logic [7:0] cmd_r;
  logic cmd_seen_r;
  logic skip_next_r;
  logic [CMD_CH_W_L-1:0] ch_sel;
  logic [7:0] in_latch_r [NUM_CH];
  logic [7:0] out_latch_r [NUM_CH];
  logic pd_r;
  logic upd_tgl_r;
  logic [NUM_CH*8-1:0] code_flat;
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;

  // link-domain reset, released on the link clock
  always_ff @(posedge link.link_clk) begin
    lrst_meta_r <= rstn_i;
    lrst_n_r <= lrst_meta_r;
  end

  assign line_raw = {link.sda, link.scl};

  // two flops then a persistence filter per line
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      always_ff @(posedge link.link_clk) begin
        line_meta_r[g] <= line_raw[g];
        line_sync_r[g] <= line_meta_r[g];
      end
      always_ff @(posedge link.link_clk) begin
        if (!lrst_n_r) begin
          filt_r[g] <= 1'b1;
          filt_cnt_r[g] <= '0;
        end else if (line_sync_r[g] == filt_r[g]) begin
          filt_cnt_r[g] <= '0;
        end else if (filt_cnt_r[g] == FCW'(dac_link_pkg::FILT_CYC)) begin
          filt_r[g] <= line_sync_r[g];
          filt_cnt_r[g] <= '0;
        end else begin
          filt_cnt_r[g] <= filt_cnt_r[g] + FCW'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= filt_r[0];
      sda_q_r <= filt_r[1];
    end
  end

  // straps may be driven by logic, so resample them continuously
  always_ff @(posedge link.link_clk) begin
    pin_meta_r <= {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i};
    pin_sync_r <= pin_meta_r;
  end

  assign my_addr = dac_link_pkg::ADDR_FIXED | ({4'h0, pin_sync_r} & PIN_MASK);

  // edges only, no timing assumption, so any rate down to standstill works
  assign scl_rise = filt_r[0] & ~scl_q_r;
  assign scl_fall = ~filt_r[0] & scl_q_r;
  assign start_det = scl_q_r & filt_r[0] & sda_q_r & ~filt_r[1];
  assign stop_det = scl_q_r & filt_r[0] & ~sda_q_r & filt_r[1];
  assign rx_byte = {shift_r, filt_r[1]};
  assign byte_done = scl_rise && (bit_cnt_r == dac_link_pkg::LAST_DATA_BIT);
  assign addr_hit = (rx_byte[7:1] == my_addr) && !rx_byte[0];
  assign ch_sel = cmd_r[dac_link_pkg::CMD_CH_LSB +: CMD_CH_W_L];

  // bit counter: eight data clocks then the ack clock
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r || start_det || stop_det) begin
      bit_cnt_r <= '0;
    end else if (scl_rise) begin
      if (bit_cnt_r == dac_link_pkg::ACK_SLOT) begin
        bit_cnt_r <= '0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // data is taken only on the clock's rising edge
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      shift_r <= '0;
    end else if (scl_rise && bit_cnt_r < dac_link_pkg::ACK_SLOT) begin
      shift_r <= rx_byte[6:0];
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      state_r <= dac_link_pkg::DS_IDLE;
    end else if (start_det) begin
      state_r <= dac_link_pkg::DS_ADDR;
    end else if (stop_det) begin
      state_r <= dac_link_pkg::DS_IDLE;
    end else if (byte_done) begin
      case (state_r)
        dac_link_pkg::DS_ADDR: begin
          state_r <= addr_hit ? dac_link_pkg::DS_CMD : dac_link_pkg::DS_SKIP;
        end
        dac_link_pkg::DS_CMD: state_r <= dac_link_pkg::DS_DATA;
        dac_link_pkg::DS_DATA: state_r <= dac_link_pkg::DS_CMD;
        default: state_r <= state_r;
      endcase
    end
  end

  // ack in the ninth clock of every byte that is ours, after the state moved on
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r || start_det || stop_det) begin
      ack_on_r <= 1'b0;
    end else if (scl_fall && bit_cnt_r == dac_link_pkg::ACK_SLOT &&
                 (state_r == dac_link_pkg::DS_CMD || state_r == dac_link_pkg::DS_DATA)) begin
      ack_on_r <= 1'b1;
    end else if (scl_fall && bit_cnt_r == 4'h0) begin
      ack_on_r <= 1'b0;
    end
  end

  assign link.sda_do_d = 1'b0;
  assign link.sda_oe_d = ack_on_r;

  // command byte: a byte cut short by stop or start is never taken
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      cmd_r <= '0;
      cmd_seen_r <= 1'b0;
      skip_next_r <= 1'b0;
    end else if (start_det) begin
      cmd_seen_r <= 1'b0;
      skip_next_r <= 1'b0;
    end else if (byte_done && state_r == dac_link_pkg::DS_CMD) begin
      cmd_r <= rx_byte;
      cmd_seen_r <= 1'b1;
      skip_next_r <= rx_byte[dac_link_pkg::CMD_RST_BIT];
    end else if (byte_done && state_r == dac_link_pkg::DS_DATA) begin
      skip_next_r <= 1'b0;
    end
  end

  // input latches survive a repeated start and are only copied out at stop
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_latch_r[i] <= '0;
      end
    end else if (byte_done && state_r == dac_link_pkg::DS_CMD &&
                 rx_byte[dac_link_pkg::CMD_RST_BIT]) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_latch_r[i] <= '0;
      end
    end else if (byte_done && state_r == dac_link_pkg::DS_DATA && !skip_next_r &&
                 32'(ch_sel) < NUM_CH) begin
      in_latch_r[CHW'(ch_sel)] <= rx_byte;
    end
  end

  // all outputs change together at a stop after at least one whole command
  always_ff @(posedge link.link_clk) begin
    if (!lrst_n_r) begin
      for (int i = 0; i < NUM_CH; i++) begin
        out_latch_r[i] <= '0;
      end
      pd_r <= 1'b0;
      upd_tgl_r <= 1'b0;
    end else if (stop_det && cmd_seen_r) begin
      for (int i = 0; i < NUM_CH; i++) begin
        out_latch_r[i] <= in_latch_r[i];
      end
      pd_r <= cmd_r[dac_link_pkg::CMD_PD_BIT];
      upd_tgl_r <= ~upd_tgl_r;
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_flat
      assign code_flat[g*8 +: 8] = out_latch_r[g];
    end
  endgenerate

  // toggle crossing; latches are quiet for many core cycles around it
  always_ff @(posedge core_clk_i) begin
    tgl_meta_r <= upd_tgl_r;
    tgl_sync_r <= tgl_meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tgl_seen_r <= 1'b0;
      dac_code_o <= '0;
      power_down_o <= 1'b0;
      update_o <= 1'b0;
    end else begin
      tgl_seen_r <= tgl_sync_r;
      update_o <= tgl_sync_r ^ tgl_seen_r;
      if (tgl_sync_r ^ tgl_seen_r) begin
        dac_code_o <= code_flat;
        power_down_o <= pd_r;
      end
    end
  end
endmodule // dac_write_slave

// *** rtl/dac_bus_master.sv ***
// wishbone-controlled two-wire master that sends one write transfer to the dac
`timescale 1ns/100ps
module dac_bus_master (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  two_wire_if.host link
);
  localparam logic [dac_link_pkg::QCW-1:0] QTR_LAST = dac_link_pkg::QCW'(dac_link_pkg::QTR_CYC - 1);

  dac_link_pkg::host_state_e state_r;
  logic [6:0] slv_addr_r;
  logic [7:0] cmd_r;
  logic [7:0] data_r;
  logic pair_r;
  logic nack_r;
  logic wr_ok;
  logic go;
  logic [dac_link_pkg::QCW-1:0] qcnt_r;
  logic tick;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [1:0] idx_r;
  logic [7:0] sh_r;
  logic ack_bad_r;
  logic nack_set;
  logic last_byte;
  logic sda_meta_r;
  logic sda_sync_r;
  logic scl_oe_r;
  logic sda_oe_r;

  // bus slave: ack one cycle after the request, writes act on the ack edge
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        dac_link_pkg::REG_CTRL: wb_dat_o <= {30'h0, pair_r, 1'b0};
        dac_link_pkg::REG_STATUS: wb_dat_o <= {30'h0, nack_r, state_r != dac_link_pkg::HS_IDLE};
        dac_link_pkg::REG_SLV_ADDR: wb_dat_o <= {25'h0, slv_addr_r};
        dac_link_pkg::REG_CMD: wb_dat_o <= {24'h0, cmd_r};
        dac_link_pkg::REG_DATA: wb_dat_o <= {24'h0, data_r};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign go = wr_ok && wb_adr_i == dac_link_pkg::REG_CTRL &&
              wb_dat_i[dac_link_pkg::CTRL_GO_BIT] && state_r == dac_link_pkg::HS_IDLE;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      slv_addr_r <= '0;
      cmd_r <= '0;
      data_r <= '0;
      pair_r <= 1'b1;
    end else if (wr_ok) begin
      case (wb_adr_i)
        dac_link_pkg::REG_CTRL: pair_r <= wb_dat_i[dac_link_pkg::CTRL_PAIR_BIT];
        dac_link_pkg::REG_SLV_ADDR: slv_addr_r <= wb_dat_i[6:0];
        dac_link_pkg::REG_CMD: cmd_r <= wb_dat_i[7:0];
        dac_link_pkg::REG_DATA: data_r <= wb_dat_i[7:0];
        default: pair_r <= pair_r;
      endcase
    end
  end

  // sticky no-ack flag: hardware set wins over a write-one clear
  assign nack_set = tick && state_r == dac_link_pkg::HS_BITS && phase_r == 2'h3 &&
                    bit_r == dac_link_pkg::ACK_SLOT && ack_bad_r;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      nack_r <= 1'b0;
    end else if (nack_set) begin
      nack_r <= 1'b1;
    end else if (wr_ok && wb_adr_i == dac_link_pkg::REG_STATUS &&
                 wb_dat_i[dac_link_pkg::STAT_NACK_BIT]) begin
      nack_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    sda_meta_r <= link.sda;
    sda_sync_r <= sda_meta_r;
  end

  // quarter-period divider sets the scl rate
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || state_r == dac_link_pkg::HS_IDLE || qcnt_r == QTR_LAST) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + dac_link_pkg::QCW'(1);
    end
  end
  assign tick = state_r != dac_link_pkg::HS_IDLE && qcnt_r == QTR_LAST;
  assign last_byte = idx_r == (pair_r ? dac_link_pkg::LAST_IDX_PAIR : dac_link_pkg::LAST_IDX_LONE);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= dac_link_pkg::HS_IDLE;
      phase_r <= '0;
      bit_r <= '0;
      idx_r <= '0;
      sh_r <= '0;
      ack_bad_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (go) begin
      state_r <= dac_link_pkg::HS_START;
      phase_r <= '0;
    end else if (tick) begin
      phase_r <= phase_r + 2'h1;
      case (state_r)
        dac_link_pkg::HS_START: begin
          if (phase_r == 2'h1) sda_oe_r <= 1'b1;
          if (phase_r == 2'h3) begin
            scl_oe_r <= 1'b1;
            state_r <= dac_link_pkg::HS_BITS;
            bit_r <= '0;
            idx_r <= '0;
            sh_r <= {slv_addr_r, 1'b0};
          end
        end
        dac_link_pkg::HS_BITS: begin
          case (phase_r)
            2'h0: sda_oe_r <= (bit_r != dac_link_pkg::ACK_SLOT) && !sh_r[7];
            2'h1: scl_oe_r <= 1'b0;
            2'h2: ack_bad_r <= sda_sync_r;
            default: begin
              scl_oe_r <= 1'b1;
              if (bit_r != dac_link_pkg::ACK_SLOT) begin
                bit_r <= bit_r + 4'h1;
                sh_r <= {sh_r[6:0], 1'b0};
              end else begin
                bit_r <= '0;
                idx_r <= idx_r + 2'h1;
                sh_r <= (idx_r == 2'h0) ? cmd_r : data_r;
                if (ack_bad_r || last_byte) state_r <= dac_link_pkg::HS_STOP;
              end
            end
          endcase
        end
        dac_link_pkg::HS_STOP: begin
          case (phase_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            default: state_r <= dac_link_pkg::HS_IDLE;
          endcase
        end
        default: state_r <= dac_link_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.scl_do_h = 1'b0;
  assign link.sda_do_h = 1'b0;
  assign link.scl_oe_h = scl_oe_r;
  assign link.sda_oe_h = sda_oe_r;
endmodule // dac_bus_master

// *** dv/dac_link_properties.sv ***
// concurrent checks on the two-wire link between the dac master and slave
`timescale 1ns/100ps
module dac_link_properties (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic link_clk,
  input wire logic sda_oe_h,
  input wire logic sda_oe_d,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic [4:0] low_cnt_r;
  logic start_ev;
  logic stop_ev;

  assign start_ev = scl && scl_q_r && sda_q_r && !sda;
  assign stop_ev = scl && scl_q_r && !sda_q_r && sda;

  always_ff @(posedge core_clk_i) begin
    scl_q_r <= rstn_i ? scl : 1'b1;
    sda_q_r <= rstn_i ? sda : 1'b1;
  end
  // scl rises since start or stop; 8 means the ack clock is next
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || start_ev || stop_ev)
      bit_cnt_r <= 4'h0;
    else if (scl && !scl_q_r)
      bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
  end
  // saturates so a stalled bus cannot wrap into a short count
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || scl)
      low_cnt_r <= 5'h0;
    else if (low_cnt_r != 5'h1f)
      low_cnt_r <= low_cnt_r + 5'h1;
  end

  sequence s_start;
    start_ev;
  endsequence
  sequence s_ack_clock;
    $rose(scl) ##0 (bit_cnt_r == 4'h8);
  endsequence

  a_ack_in_slot: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(scl) && sda_oe_d |-> bit_cnt_r == 4'h8) else $error("ack outside ninth clock");
  a_ack_raise_low: assert property (@(posedge link_clk) disable iff (!rstn_i)
    $rose(sda_oe_d) |-> !scl) else $error("ack raised with clock high");
  a_ack_stands: assert property (@(posedge link_clk) disable iff (!rstn_i)
    scl && sda_oe_d |=> sda_oe_d || !scl) else $error("ack dropped with clock high");
  a_host_frees_ack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_ack_clock |-> !sda_oe_h) else $error("master holds data in ack clock");
  a_data_setup: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(scl) |-> $stable(sda_oe_h) && sda_oe_h == $past(sda_oe_h, 2))
    else $error("data moved near clock rise");
  a_scl_high_min: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(scl) |-> scl [*6]) else $error("clock high too short");
  a_scl_low_min: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(scl) |-> low_cnt_r >= 5'h0d) else $error("clock low too short");
  a_start_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_start |-> scl [*6] ##0 !sda_oe_d) else $error("start hold too short");
  a_stop_setup: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    stop_ev |-> $past(scl, 6)) else $error("stop setup too short");
endmodule // dac_link_properties

// *** dv/tb.sv ***
// self-checking bench: wishbone-driven master writing the dac slave over the link
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] UNMAPPED = 8'h20;
  logic core_clk_i;
  logic rstn_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat;
  logic [3:0] wb_sel;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [2:0] pins;
  logic [31:0] dac_code;
  logic pd;
  logic upd;
  logic note_rd;
  logic [31:0] rng;
  logic [6:0] dev_addr;
  logic [7:0] in_m [4];
  logic [31:0] exp_rd [$];
  logic [32:0] exp_out [$];
  int err_count;
  int n_tests;

  two_wire_if bus ();
  dac_write_slave #(.NUM_CH(4), .ADDR_PINS(3)) dac_write_slave_i (
    .link(bus),
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .addr_select_pin_0_i(pins[0]),
    .addr_select_pin_1_i(pins[1]),
    .addr_select_pin_2_i(pins[2]),
    .dac_code_o(dac_code),
    .power_down_o(pd),
    .update_o(upd)
  );
  dac_bus_master dac_bus_master_i (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel),
    .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack),
    .link(bus)
  );
  dac_link_properties dac_link_properties_i (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .link_clk(bus.link_clk),
    .sda_oe_h(bus.sda_oe_h),
    .sda_oe_d(bus.sda_oe_d),
    .scl(bus.scl),
    .sda(bus.sda)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // offset start so link edges drift against core edges
  initial begin
    bus.link_clk = 1'b0;
    #17;
    forever #62.5 bus.link_clk = ~bus.link_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_rd(input logic [31:0] got);
    logic [31:0] e;
    e = exp_rd.size() > 0 ? exp_rd.pop_front() : 'x;
    n_tests++;
    if (got !== e) fail($sformatf("read %h, wanted %h", got, e));
  endtask
  task automatic chk_out(input logic [32:0] got);
    logic [32:0] e;
    e = exp_out.size() > 0 ? exp_out.pop_front() : 'x;
    n_tests++;
    if (got !== e) fail($sformatf("outputs %h, wanted %h", got, e));
  endtask

  always @(posedge core_clk_i) begin
    if (wb_ack === 1'b1 && note_rd)
      chk_rd(wb_rdat);
    if (upd === 1'b1)
      chk_out({pd, dac_code});
  end

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic chk, output logic [31:0] rd);
    int n;
    @(posedge core_clk_i);
    note_rd = chk && !we;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n == 50) begin
      fail("no bus ack");
      give_verdict();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    wb_xfer(1'b1, adr, dat, 1'b0, r);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] r;
    exp_rd.push_back(e);
    wb_xfer(1'b0, adr, 32'h0, 1'b1, r);
  endtask

  // one framed write; the model commits all input latches at the stop
  task automatic xfer(input logic [6:0] sa, input logic [7:0] cmd, input logic [7:0] dat,
                      input logic pair);
    logic [31:0] r;
    int n;
    if (sa == dev_addr) begin
      if (cmd[4])
        in_m = '{default: 8'h00};
      else if (pair && cmd[2:0] < 3'h4)
        in_m[cmd[1:0]] = dat;
      exp_out.push_back({cmd[3], in_m[3], in_m[2], in_m[1], in_m[0]});
    end
    wr(dac_link_pkg::REG_SLV_ADDR, {25'h0, sa});
    wr(dac_link_pkg::REG_CMD, {24'h0, cmd});
    wr(dac_link_pkg::REG_DATA, {24'h0, dat});
    wr(dac_link_pkg::REG_CTRL, {30'h0, pair, 1'b1});
    rd_chk(dac_link_pkg::REG_STATUS, 32'h1);
    n = 0;
    do begin
      wb_xfer(1'b0, dac_link_pkg::REG_STATUS, 32'h0, 1'b0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 1000);
    if (n == 1000) fail("transfer never finished");
    rd_chk(dac_link_pkg::REG_STATUS, (sa == dev_addr) ? 32'h0 : 32'h2);
    if (sa != dev_addr) wr(dac_link_pkg::REG_STATUS, 32'h2);
  endtask

  initial begin
    rstn_i = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    wb_sel = 4'hf;
    note_rd = 1'b0;
    err_count = 0;
    n_tests = 0;
    rng = xorshift(32'h12);
    pins = rng[2:0];
    in_m = '{default: 8'h00};
    dev_addr = {dac_link_pkg::ADDR_FIXED[6:3], pins};
    // link side resyncs reset; it still sees it low long before the first start
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd_chk(dac_link_pkg::REG_CTRL, 32'h2);
    rd_chk(dac_link_pkg::REG_STATUS, 32'h0);
    wr(UNMAPPED, 32'hff);
    rd_chk(UNMAPPED, 32'h0);
    wr(dac_link_pkg::REG_DATA, 32'h5a);
    wb_sel <= 4'he;
    wr(dac_link_pkg::REG_DATA, 32'ha5);
    wb_sel <= 4'hf;
    rd_chk(dac_link_pkg::REG_DATA, 32'h5a);
    for (int ch = 0; ch < 8; ch++) begin
      rng = xorshift(rng);
      xfer(dev_addr, 8'(ch), rng[7:0], 1'b1);
    end
    xfer(dev_addr, 8'h0a, 8'h3c, 1'b1);
    xfer(dev_addr, 8'h00, 8'hc3, 1'b0);
    xfer(dev_addr, 8'h11, 8'hff, 1'b1);
    xfer(dev_addr ^ 7'h01, 8'h02, 8'h77, 1'b1);
    xfer(dev_addr ^ 7'h40, 8'h02, 8'h77, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rng = xorshift(rng);
      xfer(dev_addr, {4'h0, rng[11], rng[10:8]}, rng[7:0], rng[12]);
    end
    repeat (50) @(posedge core_clk_i);
    if (exp_out.size() != 0) fail("output update missing");
    give_verdict();
  end

  initial begin
    repeat (80000) @(posedge core_clk_i);
    fail("watchdog expired");
    give_verdict();
  end
endmodule // tb
